// *** hdl/gcc_defines.vh ***
`ifndef GCC_DEFINES_VH
`define GCC_DEFINES_VH
// ==========================================================
// Register offsets (byte addresses on the register port)
`define GCC_OFF_CMD 6'h00
`define GCC_OFF_STATUS 6'h04
`define GCC_OFF_IMASK 6'h08
`define GCC_OFF_PMASK 6'h0C
`define GCC_OFF_ORIENT 6'h10
`define GCC_OFF_POSX 6'h14
`define GCC_OFF_POSY 6'h18
`define GCC_OFF_SPACE 6'h1C
`define GCC_OFF_FG 6'h20
`define GCC_OFF_BG 6'h24
`define GCC_OFF_MODE 6'h28
// ==========================================================
// Status bit positions
`define GCC_ST_TRAP 0
`define GCC_ST_READY 1
`define GCC_ST_POLL 2
// ==========================================================
// Command opcodes, held in bits 15:8 of the opcode word
`define GCC_OP_FONT_W 8'h0A
`define GCC_OP_FONT_B 8'h0B
`define GCC_OP_SPACE 8'h4D
`define GCC_OP_CLIP 8'h46
`define GCC_OP_COLORS 8'h3D
`define GCC_OP_BITMAP 8'h1A
`define GCC_OP_BLT 8'h64
`define GCC_OP_CHAR 8'h70
`define GCC_OP_LSB 8
`define GCC_WIDTH_SEL_BIT 8
// ==========================================================
// Descriptor first word fields
`define GCC_DESC_W_LSB 0
`define GCC_DESC_H_LSB 8
`define GCC_DESC_S_BIT 14
`define GCC_DESC_T_BIT 15
// ==========================================================
// Reset values
`define GCC_RST_MASK 1'b1
`define GCC_RST_WORD 16'h0000
`endif

// *** hdl/gcc_advance.v ***
`timescale 1ns/1ps
// ==========================================================
// Next draw position after one glyph
module gcc_advance (
   input wire [15:0] x_i,
   input wire [15:0] y_i,
   input wire [1:0] path_i,
   input wire [1:0] rot_i,
   input wire [3:0] w_m1_i,
   input wire [3:0] h_m1_i,
   input wire [15:0] space_i,
   output reg [15:0] next_x_o,
   output reg [15:0] next_y_o
);
   // Quarter turns swap which cell side lies along the path
   wire [15:0] size = rot_i[0] ? ({12'h000, h_m1_i} + 16'h0001) :
      ({12'h000, w_m1_i} + 16'h0001);
   // Two's complement add, so negative spacing kerns
   wire [15:0] step = size + space_i;

   // Path is counterclockwise, y grows downward
   always @* begin
      next_x_o = x_i;
      next_y_o = y_i;
      case (path_i)
         2'b00: next_x_o = x_i + step;
         2'b01: next_y_o = y_i - step;
         2'b10: next_x_o = x_i - step;
         default: next_y_o = y_i + step;
      endcase
   end
endmodule

// *** hdl/gcc_clip.v ***
`timescale 1ns/1ps
// ==========================================================
// Pixel write permission against clip and bitmap
module gcc_clip (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [15:0] xmin_i,
   input wire [15:0] ymin_i,
   input wire [15:0] xmax_i,
   input wire [15:0] ymax_i,
   input wire [15:0] bxmax_i,
   input wire [15:0] bymax_i,
   input wire [15:0] pix_x_i,
   input wire [15:0] pix_y_i,
   input wire pix_valid_i,
   output reg pix_ok_o
);
   // Signed window test; lo above hi can never pass
   function f_in;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         f_in = ($signed(v) >= $signed(lo)) &&
            ($signed(v) <= $signed(hi));
      end
   endfunction

   // Registered answer, one cycle after the query
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pix_ok_o <= 1'b0;
      end else begin
         pix_ok_o <= pix_valid_i &&
            f_in(pix_x_i, xmin_i, xmax_i) &&
            f_in(pix_y_i, ymin_i, ymax_i) &&
            f_in(pix_x_i, 16'h0000, bxmax_i) &&
            f_in(pix_y_i, 16'h0000, bymax_i);
      end
   end
endmodule

// *** hdl/gcc_core.v ***
`timescale 1ns/1ps
`include "gcc_defines.vh"
module gcc_core #(
   parameter ADDR_W = 22
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [5:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   output reg mem_req_o,
   output reg [ADDR_W-1:0] mem_addr_o,
   input wire [15:0] mem_rdata_i,
   input wire mem_ack_i,
   input wire [15:0] pix_x_i,
   input wire [15:0] pix_y_i,
   input wire pix_valid_i,
   output wire pix_ok_o,
   output reg [15:0] fg_color_o,
   output reg [15:0] bg_color_o,
   output reg [15:0] pos_x_o,
   output reg [15:0] pos_y_o,
   output reg irq_o,
   output reg poll_o
);
   // ==========================================================
   // States
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_PARAM = 5'b00010;
   localparam [4:0] S_EXEC = 5'b00100;
   localparam [4:0] S_TBL = 5'b01000;
   localparam [4:0] S_DESC = 5'b10000;

   // ==========================================================
   // Functions
   // Parameter words that follow each opcode
   function [2:0] f_nparams;
      input [7:0] op;
      begin
         case (op)
            `GCC_OP_FONT_W: f_nparams = 3'd2;
            `GCC_OP_FONT_B: f_nparams = 3'd2;
            `GCC_OP_SPACE: f_nparams = 3'd1;
            `GCC_OP_CLIP: f_nparams = 3'd4;
            `GCC_OP_COLORS: f_nparams = 3'd2;
            `GCC_OP_BITMAP: f_nparams = 3'd4;
            `GCC_OP_BLT: f_nparams = 3'd1;
            `GCC_OP_CHAR: f_nparams = 3'd1;
            default: f_nparams = 3'd0;
         endcase
      end
   endfunction

   // Font base plus a doubled word offset
   function [ADDR_W-1:0] f_addr;
      input [ADDR_W-1:0] base;
      input [15:0] off;
      begin
         f_addr = base + {{(ADDR_W-17){1'b0}}, off, 1'b0};
      end
   endfunction

   // ==========================================================
   // State and storage
   reg [4:0] state;
   reg [7:0] op;
   reg [2:0] need;
   reg [2:0] cnt;
   reg [15:0] p0;
   reg [15:0] p1;
   reg [15:0] p2;
   reg [15:0] p3;
   reg [ADDR_W-1:0] font_base;
   reg byte_mode;
   reg [15:0] space;
   reg [15:0] clip_xmin;
   reg [15:0] clip_ymin;
   reg [15:0] clip_xmax;
   reg [15:0] clip_ymax;
   reg [15:0] bmp_xmax;
   reg [15:0] bmp_ymax;
   reg [1:0] path;
   reg [1:0] rot;
   reg trap;
   reg imask;
   reg pmask;

   // ==========================================================
   // Bus decode
   wire poll_state = trap & ~pmask;
   wire cmd_ready = ((state == S_IDLE) || (state == S_PARAM)) &&
      !poll_state;
   wire cmd_wr = wr_i && (addr_i == `GCC_OFF_CMD) && cmd_ready;
   wire st_wr = wr_i && (addr_i == `GCC_OFF_STATUS);
   wire [2:0] op_need = f_nparams(wdata_i[15:`GCC_OP_LSB]);
   // Upper base bits beyond the address width are dropped on purpose
   wire [31:0] base_word = {p1, p0};
   wire desc_t = mem_rdata_i[`GCC_DESC_T_BIT];
   wire desc_s = mem_rdata_i[`GCC_DESC_S_BIT];
   wire [15:0] adv_x;
   wire [15:0] adv_y;

   // ==========================================================
   // Glyph advance and pixel clip
   gcc_advance u_adv (
      .x_i(pos_x_o),
      .y_i(pos_y_o),
      .path_i(path),
      .rot_i(rot),
      .w_m1_i(mem_rdata_i[`GCC_DESC_W_LSB+3:`GCC_DESC_W_LSB]),
      .h_m1_i(mem_rdata_i[`GCC_DESC_H_LSB+3:`GCC_DESC_H_LSB]),
      .space_i(space),
      .next_x_o(adv_x),
      .next_y_o(adv_y)
   );

   gcc_clip u_clip (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .xmin_i(clip_xmin),
      .ymin_i(clip_ymin),
      .xmax_i(clip_xmax),
      .ymax_i(clip_ymax),
      .bxmax_i(bmp_xmax),
      .bymax_i(bmp_ymax),
      .pix_x_i(pix_x_i),
      .pix_y_i(pix_y_i),
      .pix_valid_i(pix_valid_i),
      .pix_ok_o(pix_ok_o)
   );

   // ==========================================================
   // Command interpreter and its registers
   // Spacing is cleared only so simulation stays free of
   // unknowns; software must still load it before use.
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state <= S_IDLE;
         op <= 8'h00;
         need <= 3'd0;
         cnt <= 3'd0;
         p0 <= `GCC_RST_WORD;
         p1 <= `GCC_RST_WORD;
         p2 <= `GCC_RST_WORD;
         p3 <= `GCC_RST_WORD;
         font_base <= {ADDR_W{1'b0}};
         byte_mode <= 1'b0;
         space <= `GCC_RST_WORD;
         clip_xmin <= `GCC_RST_WORD;
         clip_ymin <= `GCC_RST_WORD;
         clip_xmax <= `GCC_RST_WORD;
         clip_ymax <= `GCC_RST_WORD;
         bmp_xmax <= `GCC_RST_WORD;
         bmp_ymax <= `GCC_RST_WORD;
         fg_color_o <= `GCC_RST_WORD;
         bg_color_o <= `GCC_RST_WORD;
         pos_x_o <= `GCC_RST_WORD;
         pos_y_o <= `GCC_RST_WORD;
         path <= 2'b00;
         rot <= 2'b00;
         trap <= 1'b0;
         imask <= `GCC_RST_MASK;
         pmask <= `GCC_RST_MASK;
         mem_req_o <= 1'b0;
         mem_addr_o <= {ADDR_W{1'b0}};
      end else begin
         // Plain control registers
         if (wr_i && (addr_i == `GCC_OFF_IMASK)) begin
            imask <= wdata_i[0];
         end
         if (wr_i && (addr_i == `GCC_OFF_PMASK)) begin
            pmask <= wdata_i[0];
         end
         if (wr_i && (addr_i == `GCC_OFF_ORIENT)) begin
            path <= wdata_i[1:0];
            rot <= wdata_i[3:2];
         end
         // Write one clears the trap; a new trap below wins
         if (st_wr && wdata_i[`GCC_ST_TRAP]) begin
            trap <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               if (cmd_wr) begin
                  op <= wdata_i[15:`GCC_OP_LSB];
                  need <= op_need;
                  cnt <= 3'd0;
                  state <= (op_need == 3'd0) ? S_EXEC : S_PARAM;
               end
            end
            S_PARAM: begin
               if (cmd_wr) begin
                  case (cnt)
                     3'd0: p0 <= wdata_i;
                     3'd1: p1 <= wdata_i;
                     3'd2: p2 <= wdata_i;
                     default: p3 <= wdata_i;
                  endcase
                  cnt <= cnt + 3'd1;
                  if (cnt == need - 3'd1) begin
                     state <= S_EXEC;
                  end
               end
            end
            S_EXEC: begin
               state <= S_IDLE;
               case (op)
                  `GCC_OP_FONT_W, `GCC_OP_FONT_B: begin
                     font_base <= base_word[ADDR_W-1:0];
                     byte_mode <= op[`GCC_WIDTH_SEL_BIT -
                        `GCC_OP_LSB];
                  end
                  `GCC_OP_SPACE: begin
                     space <= p0;
                  end
                  `GCC_OP_CLIP: begin
                     clip_xmin <= p0;
                     clip_ymin <= p1;
                     clip_xmax <= p2;
                     clip_ymax <= p3;
                  end
                  `GCC_OP_COLORS: begin
                     fg_color_o <= p0;
                     bg_color_o <= p1;
                  end
                  `GCC_OP_BITMAP: begin
                     bmp_xmax <= p2;
                     bmp_ymax <= p3;
                     clip_xmin <= 16'h0000;
                     clip_ymin <= 16'h0000;
                     clip_xmax <= p2;
                     clip_ymax <= p3;
                     pos_x_o <= 16'h0000;
                     pos_y_o <= 16'h0000;
                  end
                  `GCC_OP_BLT: begin
                     pos_x_o <= pos_x_o + p0 + space;
                  end
                  `GCC_OP_CHAR: begin
                     mem_req_o <= 1'b1;
                     if (byte_mode) begin
                        mem_addr_o <= f_addr(font_base,
                           {8'h00, p0[7:0]});
                        state <= S_TBL;
                     end else begin
                        mem_addr_o <= f_addr(font_base, p0);
                        state <= S_DESC;
                     end
                  end
                  default: begin
                     state <= S_IDLE;
                  end
               endcase
            end
            S_TBL: begin
               // Offset table entry leads to the descriptor
               if (mem_ack_i) begin
                  mem_addr_o <= f_addr(font_base, mem_rdata_i);
                  state <= S_DESC;
               end
            end
            S_DESC: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  state <= S_IDLE;
                  if (desc_t) begin
                     trap <= 1'b1;
                  end
                  // Inhibit set keeps the position as it is
                  if (!desc_s) begin
                     pos_x_o <= adv_x;
                     pos_y_o <= adv_y;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Exception outputs, a mask bit of one blocks the event
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         poll_o <= 1'b0;
      end else begin
         irq_o <= trap & ~imask;
         poll_o <= poll_state;
      end
   end

   // ==========================================================
   // Read port, data one cycle after the strobe
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            `GCC_OFF_STATUS: rdata_o <= {13'h0000, poll_state,
               cmd_ready, trap};
            `GCC_OFF_IMASK: rdata_o <= {15'h0000, imask};
            `GCC_OFF_PMASK: rdata_o <= {15'h0000, pmask};
            `GCC_OFF_ORIENT: rdata_o <= {12'h000, rot, path};
            `GCC_OFF_POSX: rdata_o <= pos_x_o;
            `GCC_OFF_POSY: rdata_o <= pos_y_o;
            `GCC_OFF_SPACE: rdata_o <= space;
            `GCC_OFF_FG: rdata_o <= fg_color_o;
            `GCC_OFF_BG: rdata_o <= bg_color_o;
            `GCC_OFF_MODE: rdata_o <= {15'h0000, byte_mode};
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end
endmodule

// *** verif/gcc_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port-level checker for the command core
module gcc_chk #(
   parameter ADDR_W = 22
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [5:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   input wire mem_req_o,
   input wire [ADDR_W-1:0] mem_addr_o,
   input wire [15:0] mem_rdata_i,
   input wire mem_ack_i,
   input wire [15:0] pix_x_i,
   input wire [15:0] pix_y_i,
   input wire pix_valid_i,
   input wire pix_ok_o,
   input wire [15:0] fg_color_o,
   input wire [15:0] bg_color_o,
   input wire [15:0] pos_x_o,
   input wire [15:0] pos_y_o,
   input wire irq_o,
   input wire poll_o
);
   logic [3:0] wr_hist;
   logic [3:0] ack_hist;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Recent causes; four edges cover opcode, exec and visibility
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wr_hist <= 4'h0;
         ack_hist <= 4'h0;
      end else begin
         wr_hist <= {wr_hist[2:0], wr_i};
         ack_hist <= {ack_hist[2:0], mem_ack_i};
      end
   end
   // ==========================================================
   // Properties
   sequence s_wait_ack;
      mem_req_o && !mem_ack_i;
   endsequence
   property p_pix_window;
      pix_ok_o |-> $past(pix_valid_i);
   endproperty
   property p_addr_hold;
      s_wait_ack ##1 mem_req_o |-> $stable(mem_addr_o);
   endproperty
   property p_req_drop;
      $fell(mem_req_o) |-> ack_hist[0];
   endproperty
   property p_addr_even;
      mem_req_o |-> !mem_addr_o[0];
   endproperty
   property p_req_rise;
      $rose(mem_req_o) |-> (|wr_hist);
   endproperty
   property p_pos_cause;
      $changed(pos_x_o) || $changed(pos_y_o) |-> (|wr_hist) || (|ack_hist);
   endproperty
   property p_color_cause;
      $changed(fg_color_o) || $changed(bg_color_o) |-> (|wr_hist);
   endproperty
   property p_irq_rise;
      $rose(irq_o) || $rose(poll_o) |-> (|wr_hist) || (|ack_hist);
   endproperty
   property p_irq_fall;
      $fell(irq_o) || $fell(poll_o) |-> (|wr_hist);
   endproperty
   a_pix_window: assert property (p_pix_window)
      else $error("pixel permission without a query");
   a_addr_hold: assert property (p_addr_hold)
      else $error("font address moved before its answer");
   a_req_drop: assert property (p_req_drop)
      else $error("font request dropped without an answer");
   a_addr_even: assert property (p_addr_even)
      else $error("odd font read address");
   a_req_rise: assert property (p_req_rise)
      else $error("font request without a command");
   a_pos_cause: assert property (p_pos_cause)
      else $error("draw position moved without cause");
   a_color_cause: assert property (p_color_cause)
      else $error("colours changed without a command");
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt or poll rose without cause");
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt or poll fell without a write");
endmodule
bind gcc_core gcc_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .mem_req_o(mem_req_o),
   .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
   .mem_ack_i(mem_ack_i), .pix_x_i(pix_x_i), .pix_y_i(pix_y_i),
   .pix_valid_i(pix_valid_i), .pix_ok_o(pix_ok_o),
   .fg_color_o(fg_color_o), .bg_color_o(bg_color_o), .pos_x_o(pos_x_o),
   .pos_y_o(pos_y_o), .irq_o(irq_o), .poll_o(poll_o));

// *** verif/gcc_mem_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Font memory on the far side of the read link
module gcc_mem_model #(
   parameter ADDR_W = 22
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire req_i,
   input wire [ADDR_W-1:0] addr_i,
   output logic [15:0] rdata_o = 16'h0000,
   output logic ack_o = 1'b0
);
   logic [15:0] mem [int];
   logic [ADDR_W-1:0] seen [$];
   logic slow = 1'b0;
   logic [1:0] st;
   int cnt;
   // Idle data toggles so stale words never pass for answers
   always @(posedge mclk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!rst_n_i) begin
         st <= 2'h0;
      end else if (st == 2'h0 && req_i) begin
         cnt <= slow ? 5 : 0;
         st <= 2'h1;
      end else if (st == 2'h1 && cnt > 0) begin
         cnt <= cnt - 1;
      end else if (st == 2'h1) begin
         ack_o <= 1'b1;
         rdata_o <= mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 16'hFFFF;
         seen.push_back(addr_i);
         st <= 2'h2;
      end else if (st == 2'h2) begin
         // The address moves on the edge after ack, so skip that edge
         st <= 2'h0;
      end
   end
endmodule

// *** verif/test_glyph_clip_color_commands.sv ***
`timescale 1ns/1ps
`include "gcc_defines.vh"
// ==========================================================
// Self-checking bench for the command core
module test_glyph_clip_color_commands;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic pix_valid_i = 1'b0;
   logic [5:0] addr_i = 6'h00;
   logic [15:0] wdata_i = 16'h0000, pix_x_i = 16'h0000, pix_y_i = 16'h0000;
   wire [15:0] rdata_o, mem_rdata_i, fg_color_o, bg_color_o, pos_x_o, pos_y_o;
   wire mem_req_o, mem_ack_i, pix_ok_o, irq_o, poll_o;
   wire [21:0] mem_addr_o;
   int error_cnt = 0, compares = 0, seed = 63374, k, j;
   logic [15:0] d, px, py, dx, fg, bg, sel;
   logic signed [15:0] sp, bx, by, cx0, cy0, cx1, cy1;
   always #5 mclk_i = ~mclk_i;
   gcc_core #(.ADDR_W(22)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
      .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .pix_x_i(pix_x_i),
      .pix_y_i(pix_y_i), .pix_valid_i(pix_valid_i), .pix_ok_o(pix_ok_o),
      .fg_color_o(fg_color_o), .bg_color_o(bg_color_o), .pos_x_o(pos_x_o),
      .pos_y_o(pos_y_o), .irq_o(irq_o), .poll_o(poll_o));
   gcc_mem_model #(.ADDR_W(22)) u_mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .req_i(mem_req_o), .addr_i(mem_addr_o), .rdata_o(mem_rdata_i),
      .ack_o(mem_ack_i));
   // ==========================================================
   // Helpers
   task report_and_stop;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   function int rnd(input int n);
      int v;
      v = $random(seed);
      return (v & 32'h7FFFFFFF) % n;
   endfunction
   // Pixel may update only inside both clip and bitmap, signed
   function logic exp_pix(input logic signed [15:0] x,
      input logic signed [15:0] y);
      return x >= cx0 && x <= cx1 && y >= cy0 && y <= cy1 && x >= 0 &&
         x <= bx && y >= 0 && y <= by;
   endfunction
   task wr(input logic [5:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [5:0] a, output logic [15:0] v);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task wait_ready;
      int i;
      logic [15:0] s;
      for (i = 0; i < 200; i++) begin
         rd(`GCC_OFF_STATUS, s);
         if (s[`GCC_ST_READY] === 1'b1) return;
      end
      error_cnt++;
      $display("[ERR] %0t ready never came", $time);
      report_and_stop;
   endtask
   // Reserved opcode bits always zero
   task cmd(input logic [7:0] op, input logic [15:0] p [0:3], input int n);
      int i;
      wait_ready;
      wr(`GCC_OFF_CMD, {op, 8'h00});
      for (i = 0; i < n; i++) wr(`GCC_OFF_CMD, p[i]);
      repeat (2) @(posedge mclk_i);
      wait_ready;
   endtask
   task pix(input logic signed [15:0] x, input logic signed [15:0] y);
      @(posedge mclk_i);
      pix_valid_i <= 1'b1;
      pix_x_i <= x;
      pix_y_i <= y;
      @(posedge mclk_i);
      pix_valid_i <= 1'b0;
      #1 check({15'h0000, pix_ok_o}, 16'(exp_pix(x, y)), "pixel");
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1 check(pos_x_o | fg_color_o | {15'h0000, irq_o}, 16'h0000, "reset");
      rd(6'h2C, d);
      check(d, 16'h0000, "unmapped read");
      bx = 16'sd63;
      by = 16'sd31;
      cmd(`GCC_OP_BITMAP, '{16'h0000, 16'h0000, bx, by}, 4);
      px = 16'h0000;
      cx0 = 0;
      cy0 = 0;
      cx1 = bx;
      cy1 = by;
      for (j = 0; j < 10; j++) pix(rnd(80) - 8, rnd(48) - 8);
      $display("bitmap test done");
      // Clip corners non-negative and inside the bitmap; pass 1 inverted
      for (k = 0; k < 3; k++) begin
         cx0 = 1 + rnd(31);
         cy0 = rnd(16);
         cy1 = cy0 + rnd(16);
         cx1 = (k == 1) ? cx0 - 1 : cx0 + rnd(32);
         cmd(`GCC_OP_CLIP, '{cx0, cy0, cx1, cy1}, 4);
         pix(cx0, cy0);
         pix(cx1, cy1);
         for (j = 0; j < 8; j++) pix(rnd(80) - 8, rnd(48) - 8);
      end
      cmd(`GCC_OP_BITMAP, '{16'h0000, 16'h0000, bx, by}, 4);
      cx0 = 0;
      cy0 = 0;
      cx1 = bx;
      cy1 = by;
      pix(0, 0);
      pix(bx, by);
      $display("clip test done");
      for (k = 0; k < 3; k++) begin
         fg = {8{2'(rnd(4))}};
         bg = {8{2'(rnd(4))}};
         cmd(`GCC_OP_COLORS, '{fg, bg, 16'h0000, 16'h0000}, 2);
         check(fg_color_o, fg, "foreground");
         check(bg_color_o, bg, "background");
      end
      $display("colour test done");
      for (k = 0; k < 3; k++) begin
         sp = (k == 0) ? -16'sd3 : 16'(rnd(9) - 4);
         cmd(`GCC_OP_SPACE, '{sp, 16'h0000, 16'h0000, 16'h0000}, 1);
         rd(`GCC_OFF_SPACE, d);
         check(d, sp, "spacing");
         dx = 16'(1 + rnd(20));
         cmd(`GCC_OP_BLT, '{dx, 16'h0000, 16'h0000, 16'h0000}, 1);
         px = px + dx + sp;
         check(pos_x_o, px, "transfer x");
         check(pos_y_o, 16'h0000, "transfer y");
      end
      cmd(`GCC_OP_BLT, '{dx, 16'h0000, 16'h0000, 16'h0000}, 1);
      px = px + dx + sp;
      check(pos_x_o, px, "spacing kept");
      $display("spacing test done");
      // Word fonts: 9 rows by 6 columns, sizes minus one
      cmd(`GCC_OP_FONT_W, '{16'h0100, 16'h0000, 16'h0000, 16'h0000}, 2);
      rd(`GCC_OFF_MODE, d);
      check(d & 16'h0001, 16'h0000, "word mode");
      for (k = 0; k < 3; k++) begin
         sel = 16'(16 + rnd(32));
         u_mem.mem[256 + 2 * sel] = {k == 2, k == 1, 6'h08, 8'h05};
         u_mem.slow = k[0];
         u_mem.seen.delete();
         cmd(`GCC_OP_CHAR, '{sel, 16'h0000, 16'h0000, 16'h0000}, 1);
         check(u_mem.seen[0][15:0], 16'h0100 + 2 * sel, "word address");
         if (k != 1) px = px + 16'h0006 + sp;
         check(pos_x_o, px, "glyph advance");
      end
      rd(`GCC_OFF_STATUS, d);
      check(d & 16'h0001, 16'h0001, "trap flag");
      check({15'h0000, irq_o}, 16'h0000, "masked interrupt");
      wr(`GCC_OFF_IMASK, 16'h0000);
      wr(`GCC_OFF_PMASK, 16'h0000);
      repeat (2) @(posedge mclk_i);
      check({14'h0000, irq_o, poll_o}, 16'h0003, "trap signalled");
      wr(`GCC_OFF_STATUS, 16'h0001);
      repeat (2) @(posedge mclk_i);
      check({14'h0000, irq_o, poll_o}, 16'h0000, "trap cleared");
      wr(`GCC_OFF_IMASK, 16'h0001);
      wr(`GCC_OFF_PMASK, 16'h0001);
      $display("word font test done");
      cmd(`GCC_OP_FONT_B, '{16'h0200, 16'h0000, 16'h0000, 16'h0000}, 2);
      rd(`GCC_OFF_MODE, d);
      check(d & 16'h0001, 16'h0001, "byte mode");
      for (k = 0; k < 2; k++) begin
         sel = 16'(rnd(16));
         dx = 16'(64 + 8 * k);
         u_mem.mem[512 + 2 * sel] = dx;
         u_mem.mem[512 + 2 * dx] = 16'h0303;
         u_mem.seen.delete();
         cmd(`GCC_OP_CHAR, '{sel, 16'h0000, 16'h0000, 16'h0000}, 1);
         check(u_mem.seen[0][15:0], 16'h0200 + 2 * sel, "table address");
         check(u_mem.seen[1][15:0], 16'h0200 + 2 * dx, "glyph address");
         px = px + 16'h0004 + sp;
         check(pos_x_o, px, "byte advance");
      end
      $display("byte font test done");
      // Paths 3, 2, 1; only the first uses an odd rotation (height)
      u_mem.mem[512 + 2 * sel] = 16'h0050;
      u_mem.mem[672] = 16'h0501;
      py = 16'h0000;
      for (k = 3; k > 0; k--) begin
         wr(`GCC_OFF_ORIENT, 16'(k == 3 ? 7 : k));
         cmd(`GCC_OP_CHAR, '{sel, 16'h0000, 16'h0000, 16'h0000}, 1);
         if (k == 3) py = py + 16'h0006 + sp;
         if (k == 2) px = px - 16'h0002 - sp;
         if (k == 1) py = py - 16'h0002 - sp;
         check(pos_x_o, px, "path x");
         check(pos_y_o, py, "path y");
      end
      $display("orientation test done");
      report_and_stop;
   end
   // Hang guard
   initial begin
      repeat (50000) @(posedge mclk_i);
      error_cnt++;
      $display("[ERR] %0t run limit reached", $time);
      report_and_stop;
   end
endmodule
